// ==== include/adc_ctl_pkg.sv ====
// package: register map, field positions and types for the converter sample/convert control
package adc_ctl_pkg;
  // register word addresses (byte address, one aligned word each)
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00; // adc_control_one
  localparam logic [7:0] ADDR_ENABLE = 8'h04; // converter on bit
  localparam logic [7:0] ADDR_STATUS = 8'h08; // live conversion countdown
  localparam logic [7:0] ADDR_COUNT = 8'h0C; // internal counter preset
  // field positions inside adc_control_one
  localparam int BIT_DONE = 0;
  localparam int BIT_SAMPLE = 1;
  localparam int BIT_AUTO = 2;
  localparam int BIT_RES = 3;
  localparam int SRC_LO = 4;
  localparam int SRC_HI = 7;
  // trigger source codes
  localparam logic [3:0] SRC_MANUAL = 4'h0;
  localparam logic [3:0] SRC_EXT_EXTERNAL_INTERRUPT_ZERO = 4'h1;
  localparam logic [3:0] SRC_TIMER_THREE = 4'h2;
  localparam logic [3:0] SRC_TIMER1_SLEEP = 4'h5;
  localparam logic [3:0] SRC_TIMER1 = 4'h6;
  localparam logic [3:0] SRC_COUNTER = 4'h7;
  localparam logic [3:0] SRC_CCP_FIRST = 4'h8;
  localparam logic [3:0] SRC_CCP_LAST = 4'hD;
  localparam logic [3:0] SRC_CELL_ONE = 4'hE;
  localparam logic [3:0] SRC_CELL_TWO = 4'hF;
  // conversion lengths in core clocks (one per result bit plus one)
  localparam logic [3:0] CONV_CYC_12 = 4'hD;
  localparam logic [3:0] CONV_CYC_10 = 4'hB;
  localparam logic [7:0] COUNT_RESET = 8'h10; // internal counter default
  localparam int NUM_CCP = 6;
  // trigger inputs bundled together
  typedef struct packed {
    logic ext_external_interrupt_zero; // external_interrupt_zero level (pin)
    logic timer_three; // period match pulse
    logic timer_one; // period match pulse
    logic [NUM_CCP-1:0] ccp; // capture_compare_unit_one..six pulses
    logic logic_cell_one; // pulse
    logic logic_cell_two; // pulse
  } trig_t;
  // analog stage hand-off
  typedef struct packed {
    logic acquire; // sample-and-hold acquiring
    logic convert; // conversion running
    logic res12; // resolution to the converter
  } sha_ctl_t;
endpackage : adc_ctl_pkg

// ==== rtl/adc_sync2.sv ====
// two-flop synchroniser with edge output for the external interrupt pin
`timescale 1ns/1ps
module adc_sync2 (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pin side
  input wire logic pin_in,
  input wire logic rising, // which edge counts as active
  // core side
  output logic edge_pulse
);
  logic meta_r; // first stage, read only by stage two
  logic sync_r; // second stage
  logic prev_r; // previous synced level for edge detect

  // synchroniser chain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edge picked by polarity
  assign edge_pulse = rising ? (sync_r & ~prev_r) : (~sync_r & prev_r);
endmodule : adc_sync2

// ==== rtl/adc_sample_convert_control.sv ====
// converter sample/convert sequencer with control register and trigger selection
// Operation
// RL1: code 1111 lets logic cell two trigger
// RL2: codes 1000-1101 pick capture/compare units one-six
// RL3: code 0010 lets timer three match trigger
// RL4: code 0001 lets external interrupt edge trigger
// RL5: code 0000 means sample-enable clear triggers
// RL6: resolution bit one is 12-bit, zero 10-bit
// RL7: auto-start resamples after conversion, sets sample-enable
// RL8: sample-enable reads one while acquiring only
// RL9: writing one starts sampling when auto-start clear
// RL10: writing zero converts when source is 0000
// RL11: done flag shows a finished conversion
// RL12: clearing done leaves running work untouched
// RL13: auto mode clears done at next sample
// RL14: disabled converter holds sample-enable zero
// RL15: done sets with result valid, same cycle
`timescale 1ns/1ps
module adc_sample_convert_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // trigger sources
  input wire adc_ctl_pkg::trig_t trig,
  // analog stage
  output adc_ctl_pkg::sha_ctl_t sha_ctl,
  output logic result_valid
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;

  state_t state_r; // sequencer state
  logic on_r; // converter enable
  logic [3:0] src_r; // trigger_source_select
  logic res_r; // resolution_select
  logic auto_r; // sample_auto_start
  logic done_r; // conversion done flag
  logic [7:0] cnt_preset_r; // internal counter sample length
  logic [7:0] sample_enable_cnt_r; // internal counter
  logic [3:0] conv_cnt_r; // conversion countdown
  logic result_valid_r; // result strobe
  logic [31:0] rdata_r; // read data register
  logic ext_edge; // synchronised pin edge
  logic trig_hit; // selected hardware trigger
  logic wr_ctl; // write to control register
  logic start_sample_enable; // begin acquisition
  logic end_sample_enable; // end acquisition, convert
  logic conv_last; // final conversion cycle

  // external pin enters through two flops
  adc_sync2 u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in(trig.ext_external_interrupt_zero),
    .rising(1'b1),
    .edge_pulse(ext_edge)
  );

  assign wr_ctl = reg_wr && (reg_addr == adc_ctl_pkg::ADDR_CONTROL_ONE);

  // hardware trigger mux
  always_comb begin
    trig_hit = 1'b0;
    unique case (src_r)
      adc_ctl_pkg::SRC_CELL_TWO: trig_hit = trig.logic_cell_two; // RL1
      adc_ctl_pkg::SRC_CELL_ONE: trig_hit = trig.logic_cell_one;
      adc_ctl_pkg::SRC_TIMER_THREE: trig_hit = trig.timer_three; // RL3
      adc_ctl_pkg::SRC_EXT_EXTERNAL_INTERRUPT_ZERO: trig_hit = ext_edge; // RL4
      adc_ctl_pkg::SRC_TIMER1, adc_ctl_pkg::SRC_TIMER1_SLEEP: trig_hit = trig.timer_one;
      adc_ctl_pkg::SRC_COUNTER: trig_hit = (sample_enable_cnt_r == 8'h00);
      default: begin
        // ccp codes map in order; reserved and manual codes never fire
        if (src_r >= adc_ctl_pkg::SRC_CCP_FIRST && src_r <= adc_ctl_pkg::SRC_CCP_LAST) begin
          trig_hit = trig.ccp[3'(src_r - adc_ctl_pkg::SRC_CCP_FIRST)]; // RL2
        end
      end
    endcase
  end

  // sample start from idle: auto-start, else writing one with auto clear; converter on only
  always_comb begin
    start_sample_enable = 1'b0;
    if (on_r && state_r == ST_IDLE) begin
      if (auto_r) begin
        start_sample_enable = 1'b1; // RL7
      end else if (wr_ctl && reg_wdata[adc_ctl_pkg::BIT_SAMPLE]) begin
        start_sample_enable = 1'b1; // RL9
      end
    end
  end

  // end of acquisition: software clear in manual code, else selected event
  always_comb begin
    end_sample_enable = 1'b0;
    if (state_r == ST_SAMPLE) begin
      if (src_r == adc_ctl_pkg::SRC_MANUAL) begin
        end_sample_enable = wr_ctl && !reg_wdata[adc_ctl_pkg::BIT_SAMPLE]; // RL5 RL10
      end else begin
        end_sample_enable = trig_hit;
      end
    end
  end

  assign conv_last = (state_r == ST_CONVERT) && (conv_cnt_r == 4'h1);

  // sequencer; disabling aborts to idle so sample-enable drops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else if (!on_r) begin
      state_r <= ST_IDLE; // RL14
    end else begin
      unique case (state_r)
        ST_IDLE: if (start_sample_enable) state_r <= ST_SAMPLE;
        ST_SAMPLE: if (end_sample_enable) state_r <= ST_CONVERT;
        ST_CONVERT: if (conv_last) state_r <= ST_IDLE; // auto restarts from idle next cycle
      endcase
    end
  end

  // conversion length follows resolution
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      conv_cnt_r <= 4'h0;
    end else if (end_sample_enable) begin
      conv_cnt_r <= res_r ? adc_ctl_pkg::CONV_CYC_12 : adc_ctl_pkg::CONV_CYC_10; // RL6
    end else if (state_r == ST_CONVERT && conv_cnt_r != 4'h0) begin
      conv_cnt_r <= conv_cnt_r - 4'h1;
    end
  end

  // internal counter runs down during acquisition
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample_enable_cnt_r <= 8'h00;
    end else if (start_sample_enable) begin
      sample_enable_cnt_r <= cnt_preset_r;
    end else if (state_r == ST_SAMPLE && sample_enable_cnt_r != 8'h00) begin
      sample_enable_cnt_r <= sample_enable_cnt_r - 8'h01;
    end
  end

  // result strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= conv_last && on_r;
    end
  end

  // done flag: set beats software clear; auto start clears it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
    end else if (conv_last && on_r) begin
      done_r <= 1'b1; // RL11 RL15
    end else if (start_sample_enable && auto_r) begin
      done_r <= 1'b0; // RL13
    end else if (wr_ctl && !reg_wdata[adc_ctl_pkg::BIT_DONE]) begin
      done_r <= 1'b0; // RL12
    end
  end

  // configuration fields; the sequencer never looks at the done write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_r <= 4'h0;
      res_r <= 1'b0;
      auto_r <= 1'b0;
      on_r <= 1'b0;
      cnt_preset_r <= adc_ctl_pkg::COUNT_RESET;
    end else begin
      if (wr_ctl) begin
        src_r <= reg_wdata[adc_ctl_pkg::SRC_HI:adc_ctl_pkg::SRC_LO];
        res_r <= reg_wdata[adc_ctl_pkg::BIT_RES];
        auto_r <= reg_wdata[adc_ctl_pkg::BIT_AUTO];
      end
      if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_ENABLE) begin
        on_r <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_COUNT) begin
        cnt_preset_r <= reg_wdata[7:0];
      end
    end
  end

  // read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        adc_ctl_pkg::ADDR_CONTROL_ONE:
          rdata_r <= {24'h00_0000, src_r, res_r, auto_r, (state_r == ST_SAMPLE), done_r}; // RL8
        adc_ctl_pkg::ADDR_ENABLE: rdata_r <= {31'h0000_0000, on_r};
        adc_ctl_pkg::ADDR_STATUS: rdata_r <= {28'h000_0000, conv_cnt_r};
        adc_ctl_pkg::ADDR_COUNT: rdata_r <= {24'h00_0000, cnt_preset_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign result_valid = result_valid_r;
  assign sha_ctl.acquire = (state_r == ST_SAMPLE); // RL8
  assign sha_ctl.convert = (state_r == ST_CONVERT);
  assign sha_ctl.res12 = res_r; // RL6

  // checks
  AST_DONE_WITH_RESULT: assert property (@(posedge core_clk) disable iff (!rstn) // RL15
    result_valid |-> done_r) else $error("done not set with result");
  AST_OFF_NO_SAMPLE: assert property (@(posedge core_clk) disable iff (!rstn) // RL14
    !on_r |=> !sha_ctl.acquire) else $error("sampling while disabled");
  AST_AUTO_RESTART: assert property (@(posedge core_clk) disable iff (!rstn) // RL7
    (result_valid && auto_r && on_r) |=> sha_ctl.acquire) else $error("no auto restart");
  AST_AUTO_CLEAR_DONE: assert property (@(posedge core_clk) disable iff (!rstn) // RL13
    ($rose(sha_ctl.acquire) && $past(auto_r)) |-> !done_r) else $error("done kept in auto");
  AST_MANUAL_START: assert property (@(posedge core_clk) disable iff (!rstn) // RL9
    (wr_ctl && reg_wdata[1] && !auto_r && on_r && state_r == ST_IDLE) |=> sha_ctl.acquire)
    else $error("manual start lost");
  AST_MANUAL_END: assert property (@(posedge core_clk) disable iff (!rstn) // RL10
    (wr_ctl && !reg_wdata[1] && src_r == 4'h0 && on_r && state_r == ST_SAMPLE) |=> sha_ctl.convert)
    else $error("manual end lost");
  AST_CELL2: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
    (src_r == 4'hF && trig.logic_cell_two && on_r && state_r == ST_SAMPLE) |=> sha_ctl.convert)
    else $error("cell two trigger lost");
  AST_TIMER_THREE: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
    (src_r == 4'h2 && trig.timer_three && on_r && state_r == ST_SAMPLE) |=> sha_ctl.convert)
    else $error("timer three trigger lost");
  AST_CONV_LEN12: assert property (@(posedge core_clk) disable iff (!rstn) // RL6
    ($rose(sha_ctl.convert) && res_r && on_r) |-> ##13 (result_valid || !on_r || $past(!on_r)))
    else $error("12-bit length wrong");
endmodule : adc_sample_convert_control

// ==== dv/adc_trig_model.sv ====
// trigger source partner: timers, capture/compare units, logic cells, interrupt pin
`timescale 1ns/1ps
module adc_trig_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bench command
  input wire logic go,
  input wire logic [3:0] pick,
  // trigger lines
  output adc_ctl_pkg::trig_t trig
);
  logic [1:0] hold_r; // pin stays high a few cycles so the synchroniser sees it
  // one pulse on the picked source per go
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trig <= '0;
      hold_r <= 2'h0;
    end else begin
      trig.timer_three <= go && pick == adc_ctl_pkg::SRC_TIMER_THREE;
      trig.timer_one <= go && pick == adc_ctl_pkg::SRC_TIMER1;
      trig.logic_cell_one <= go && pick == adc_ctl_pkg::SRC_CELL_ONE;
      trig.logic_cell_two <= go && pick == adc_ctl_pkg::SRC_CELL_TWO;
      for (int i = 0; i < adc_ctl_pkg::NUM_CCP; i++) begin
        trig.ccp[i] <= go && pick == adc_ctl_pkg::SRC_CCP_FIRST + 4'(i);
      end
      // pin level, a rising transition then low again
      if (go && pick == adc_ctl_pkg::SRC_EXT_EXTERNAL_INTERRUPT_ZERO) begin
        hold_r <= 2'h3;
      end else if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end
      trig.ext_external_interrupt_zero <= hold_r != 2'h0;
    end
  end
endmodule : adc_trig_model

// ==== dv/adc_sample_convert_control_tb.sv ====
// testbench for the converter sample/convert sequencer
`timescale 1ns/1ps
module adc_sample_convert_control_tb;
  logic core_clk, rstn, reg_wr, reg_rd, go, result_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [3:0] pick;
  adc_ctl_pkg::trig_t trig;
  adc_ctl_pkg::sha_ctl_t sha_ctl;
  int fail_count, num_checks, cnt;
  // hardware trigger codes exercised
  logic [3:0] codes [12] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  localparam logic [7:0] CTRL = adc_ctl_pkg::ADDR_CONTROL_ONE;
  adc_sample_convert_control dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig(trig), .sha_ctl(sha_ctl), .result_valid(result_valid));
  adc_trig_model partner (.core_clk(core_clk), .rstn(rstn), .go(go), .pick(pick), .trig(trig));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // one-cycle write, one idle edge before the next strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data taken just after the edge that launches it, while it stands
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd
  task automatic fire(input logic [3:0] code);
    @(posedge core_clk);
    go <= 1'b1;
    pick <= code;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : fire
  // count convert cycles up to the result pulse; clr rewrites control mid-conversion
  task automatic wait_result(input logic clr);
    int n;
    cnt = 0;
    // outputs looked at 1 ns after the edge, once settled
    #1;
    if (sha_ctl.convert === 1'b1) cnt++;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      reg_wr <= clr && cnt == 2;
      #1;
      if (sha_ctl.convert === 1'b1) cnt++;
      if (result_valid === 1'b1) break;
    end
    if (n == 40) begin
      chk("result timeout", 32'h1, 32'h0);
      give_verdict();
    end
  endtask : wait_result
  // manual sample, then the chosen trigger ends it
  task automatic run(input logic [3:0] code, input logic res, input logic clr);
    wr(CTRL, {24'h0, code, res, 3'b010});
    rd(CTRL);
    chk("sample bit set", rv[1], 32'h1);
    chk("acquiring", sha_ctl.acquire, 32'h1);
    chk("res12", sha_ctl.res12, res);
    if (code == adc_ctl_pkg::SRC_MANUAL) wr(CTRL, {24'h0, code, res, 3'b000});
    else fire(code);
    wait_result(clr);
    chk("convert cycles", cnt, res ? adc_ctl_pkg::CONV_CYC_12 : adc_ctl_pkg::CONV_CYC_10);
    chk("convert at result", sha_ctl.convert, 32'h0);
    rd(CTRL);
    chk("done", rv[0], 32'h1);
    chk("holding", rv[1], 32'h0);
  endtask : run
  // auto-start restarts sampling and drops done
  task automatic auto_mode();
    int n;
    wr(CTRL, {24'h0, adc_ctl_pkg::SRC_TIMER_THREE, 4'b0100});
    rd(CTRL);
    chk("auto sample bit", rv[1], 32'h1);
    fire(adc_ctl_pkg::SRC_TIMER_THREE);
    wait_result(1'b0);
    for (n = 0; n < 2 && sha_ctl.acquire !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("resample", sha_ctl.acquire, 32'h1);
    rd(CTRL);
    chk("auto resample bit", rv[1], 32'h1);
    chk("done dropped", rv[0], 32'h0);
  endtask : auto_mode
  initial begin
    {rstn, reg_wr, reg_rd, go, reg_addr, reg_wdata, pick} = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(CTRL);
    chk("control reset", rv, 32'h0);
    rd(adc_ctl_pkg::ADDR_COUNT);
    chk("count preset", rv, 32'(adc_ctl_pkg::COUNT_RESET));
    rd(8'h30);
    chk("unmapped", rv, 32'h0);
    // sample bit refused while the converter is off
    wr(CTRL, 32'h00000002);
    rd(CTRL);
    chk("off sample bit", rv[1], 32'h0);
    wr(adc_ctl_pkg::ADDR_ENABLE, 32'h00000001);
    run(4'h0, 1'b0, 1'b0);
    run(4'h0, 1'b1, 1'b0);
    foreach (codes[i]) run(codes[i], 1'b1, codes[i] == 4'hF);
    auto_mode();
    // switching off mid-sample clears the sample bit
    wr(adc_ctl_pkg::ADDR_ENABLE, 32'h00000000);
    rd(CTRL);
    chk("off clears sample", rv[1], 32'h0);
    give_verdict();
  end
endmodule : adc_sample_convert_control_tb
